// >>> hw/timer6_ctrl_defs.svh
`ifndef TIMER6_CTRL_DEFS_SVH
`define TIMER6_CTRL_DEFS_SVH

`define ADDR_W              16
`define TMC_OFFSET          16'hFF57
`define PORT_DIR_OFFSET     16'hFF2A
`define TMC_RESET           8'h00
`define PORT_DIR_RESET      8'hFF
`define BIT_GATE            3'h0
`define BIT_LEVEL           3'h1
`define BIT_CLR_CMD         3'h2
`define BIT_SET_CMD         3'h3
`define BIT_PWM             3'h6
`define BIT_RUN             3'h7
`define TMC_STORE_MASK      8'hC3

`endif

// >>> hw/timer6_ctrl_pkg.sv
package timer6_ctrl_pkg;

    // controls handed to the counting and waveform logic
    typedef struct packed {
        logic run;
        logic pwm_mode;
        logic level_or_toggle;
        logic output_gate;
    } timer_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } outff_cmd_t;

endpackage : timer6_ctrl_pkg

// >>> hw/timer6_mode_control.sv
`timescale 1ns/100ps
`include "timer6_ctrl_defs.svh"
module timer6_mode_control (
    input  wire logic                        clk_in,
    input  wire logic                        sys_rst_in,
    input  wire logic [`ADDR_W-1:0]          addr_in,
    input  wire logic [7:0]                  wdata_in,
    input  wire logic [7:0]                  wmask_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    input  wire logic                        match_in,
    input  wire logic                        count_wave_in,
    input  wire logic [1:0]                  port_latch_in,
    output logic [7:0]                       rdata_out,
    output timer6_ctrl_pkg::timer_ctrl_t     ctrl_out,
    output logic                             count_clear_out,
    output logic                             outff_out,
    output logic                             timer6_wave_out,
    output logic [7:0]                       port10_direction_out,
    output logic                             pin_oe_out
);

    logic [7:0] timer6_mode_control_ff;
    logic [7:0] port10_direction_ff;
    logic       outff_ff;
    logic [7:0] rdata_ff;
    logic       rd_hit_tmc_ff;

    wire sel_tmc = (addr_in == `TMC_OFFSET);
    wire sel_dir = (addr_in == `PORT_DIR_OFFSET);
    wire wr_tmc  = wr_in && sel_tmc;
    wire wr_dir  = wr_in && sel_dir;

    // bit or byte writes
    // one lane per bit, so a single-bit write never disturbs its neighbours
    logic [7:0] nxt_tmc;
    logic [7:0] nxt_dir;
    for (genvar b = 0; b < 8; b++) begin : g_wlane
        assign nxt_tmc[b] = wmask_in[b] ? wdata_in[b] : timer6_mode_control_ff[b];
        assign nxt_dir[b] = wmask_in[b] ? wdata_in[b] : port10_direction_ff[b];
    end

    wire [7:0] tmc_stored = nxt_tmc & `TMC_STORE_MASK;

    wire set_cmd = wr_tmc && wmask_in[`BIT_SET_CMD] && wdata_in[`BIT_SET_CMD];
    wire clr_cmd = wr_tmc && wmask_in[`BIT_CLR_CMD] && wdata_in[`BIT_CLR_CMD];

    wire run_bit   = timer6_mode_control_ff[`BIT_RUN];
    wire pwm_bit   = timer6_mode_control_ff[`BIT_PWM];
    wire lvl_bit   = timer6_mode_control_ff[`BIT_LEVEL];
    wire gate_bit  = timer6_mode_control_ff[`BIT_GATE];
    // toggle on match only outside pwm
    wire toggle_ev = run_bit && !pwm_bit && lvl_bit && match_in;

    wire nxt_outff = (set_cmd && !clr_cmd) ? 1'b1 :
                     (clr_cmd && !set_cmd) ? 1'b0 :
                     (set_cmd && clr_cmd)  ? outff_ff :
                     toggle_ev             ? ~outff_ff : outff_ff;

    wire [7:0] nxt_rdata = sel_tmc ? timer6_mode_control_ff :
                           sel_dir ? port10_direction_ff : 8'h00;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            timer6_mode_control_ff <= `TMC_RESET;
        end else if (wr_tmc) begin
            timer6_mode_control_ff <= tmc_stored;
        end
    end

    // direction reset to ones, per-bit direction
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            port10_direction_ff <= `PORT_DIR_RESET;
        end else if (wr_dir) begin
            port10_direction_ff <= nxt_dir;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            outff_ff <= 1'b0;
        end else begin
            outff_ff <= nxt_outff;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff      <= 8'h00;
            rd_hit_tmc_ff <= 1'b0;
        end else begin
            rdata_ff      <= rd_in ? nxt_rdata : 8'h00;
            rd_hit_tmc_ff <= rd_in && sel_tmc;
        end
    end

    assign rdata_out = rdata_ff;
    assign ctrl_out.run             = run_bit;
    assign ctrl_out.pwm_mode        = pwm_bit;
    assign ctrl_out.level_or_toggle = lvl_bit;
    assign ctrl_out.output_gate     = gate_bit;
    assign count_clear_out = !run_bit;
    assign outff_out       = outff_ff;
    wire wave_src = pwm_bit ? (count_wave_in ^ lvl_bit) : outff_ff;
    assign timer6_wave_out = gate_bit ? wave_src : 1'b0;
    assign pin_oe_out      = gate_bit && !port10_direction_ff[1];
    assign port10_direction_out = port10_direction_ff;

    reset_clear_a: assert property (@(posedge clk_in)
        sys_rst_in |=> (timer6_mode_control_ff == 8'h00 && !outff_ff))
        else $error("mode control not cleared by reset");
    reset_dir_a: assert property (@(posedge clk_in)
        sys_rst_in |=> port10_direction_ff == 8'hFF)
        else $error("direction not all ones after reset");
    cmd_readzero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rd_hit_tmc_ff |-> rdata_out[3:2] == 2'b00)
        else $error("set or clear command read back nonzero");
    outff_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (set_cmd && !clr_cmd) |=> outff_ff)
        else $error("output flip-flop not set");
    outff_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clr_cmd && !set_cmd) |=> !outff_ff)
        else $error("output flip-flop not cleared");
    outff_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (set_cmd && clr_cmd) |=> $stable(outff_ff))
        else $error("prohibited code changed flip-flop");
    gate_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !gate_bit |-> (!timer6_wave_out && !pin_oe_out))
        else $error("output driven while gate off");
    stop_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_tmc && !tmc_stored[7]) |=> (count_clear_out && !ctrl_out.run))
        else $error("stop did not clear counter");
    bit_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_dir |=>
        ((port10_direction_ff ^ $past(port10_direction_ff)) & ~$past(wmask_in)) == 8'h00)
        else $error("single-bit write disturbed other bits");
    pwm_mode_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate_bit && pwm_bit) |-> timer6_wave_out == (count_wave_in ^ lvl_bit))
        else $error("pwm output wrong level");
    toggle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (toggle_ev && !set_cmd && !clr_cmd) |=> outff_ff != $past(outff_ff))
        else $error("no toggle on match");

    // register storage checks: held, masked and loaded lane by lane

    // command and spare bits never stored
    tmc_gap_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        timer6_mode_control_ff[5:2] == 4'h0)
        else $error("mode control stored a command or spare bit");

    spare_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rd_hit_tmc_ff |-> rdata_out[5:4] == 2'h0)
        else $error("spare mode control bits read back nonzero");

    tmc_lane_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_tmc |=> ((timer6_mode_control_ff ^ $past(timer6_mode_control_ff))
                    & ~$past(wmask_in)) == 8'h00)
        else $error("mode control write touched an unmasked bit");

    tmc_lane_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_tmc |=> ((timer6_mode_control_ff ^ $past(wdata_in)) & $past(wmask_in)
                    & `TMC_STORE_MASK) == 8'h00)
        else $error("mode control write did not load a masked bit");

    tmc_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !wr_tmc |=> $stable(timer6_mode_control_ff))
        else $error("mode control changed without a write");

    dir_lane_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_dir |=> ((port10_direction_ff ^ $past(wdata_in)) & $past(wmask_in)) == 8'h00)
        else $error("direction write did not load a masked bit");

    dir_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !wr_dir |=> $stable(port10_direction_ff))
        else $error("direction changed without a write");

    unmapped_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && !sel_tmc && !sel_dir) |=>
        ($stable(timer6_mode_control_ff) && $stable(port10_direction_ff)))
        else $error("unmapped write changed a register");

    dir_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        port10_direction_out == port10_direction_ff)
        else $error("direction output differs from register");

    // control outputs to the counter, and read data and pin outputs after reset

    run_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.run == timer6_mode_control_ff[7])
        else $error("run control differs from bit seven");

    count_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        count_clear_out == !ctrl_out.run)
        else $error("count clear not the inverse of run");

    mode_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.pwm_mode == timer6_mode_control_ff[6])
        else $error("mode control differs from bit six");

    level_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.level_or_toggle == timer6_mode_control_ff[1])
        else $error("level control differs from bit one");

    gate_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.output_gate == timer6_mode_control_ff[0])
        else $error("gate control differs from bit zero");

    reset_run_a: assert property (@(posedge clk_in)
        sys_rst_in |=> (count_clear_out && !ctrl_out.run))
        else $error("counter not stopped after reset");

    reset_pins_a: assert property (@(posedge clk_in)
        sys_rst_in |=> (rdata_out == 8'h00 && !timer6_wave_out && !pin_oe_out))
        else $error("outputs active after reset");

    // pin and flip-flop behaviour

    clear_mode_pin_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate_bit && !pwm_bit) |-> timer6_wave_out == outff_ff)
        else $error("pin differs from output flip-flop");

    oe_on_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate_bit && !port10_direction_ff[1]) |-> pin_oe_out)
        else $error("pin not driven with gate on");

    oe_input_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        port10_direction_ff[1] |-> !pin_oe_out)
        else $error("pin driven while set as input");

    toggle_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!lvl_bit && !set_cmd && !clr_cmd) |=> $stable(outff_ff))
        else $error("flip-flop moved with toggle disabled");

    pwm_no_toggle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pwm_bit && !set_cmd && !clr_cmd) |=> $stable(outff_ff))
        else $error("flip-flop moved in pwm mode");

    stopped_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!run_bit && !set_cmd && !clr_cmd) |=> $stable(outff_ff))
        else $error("flip-flop moved while stopped");

    set_beats_match_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (set_cmd && !clr_cmd && toggle_ev) |=> outff_ff)
        else $error("match toggle overrode a set");

    clr_beats_match_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clr_cmd && !set_cmd && toggle_ev) |=> !outff_ff)
        else $error("match toggle overrode a clear");

    outff_pin_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        outff_out == outff_ff)
        else $error("flip-flop output differs from register");

    pwm_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate_bit && pwm_bit && lvl_bit) |-> timer6_wave_out == !count_wave_in)
        else $error("active low pwm not inverted");

    pwm_high_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (gate_bit && pwm_bit && !lvl_bit) |-> timer6_wave_out == count_wave_in)
        else $error("active high pwm inverted");

    // read path

    // read data only after a read
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data present without a read");

    unmapped_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && !sel_tmc && !sel_dir) |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");

    dir_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && sel_dir) |=> rdata_out == $past(port10_direction_ff))
        else $error("direction read returned wrong value");

    tmc_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rd_in && sel_tmc) |=> rdata_out == $past(timer6_mode_control_ff))
        else $error("mode control read returned wrong value");

    run_pwm_c: cover property (@(posedge clk_in) ctrl_out.run && ctrl_out.pwm_mode);
    toggle_c:  cover property (@(posedge clk_in) toggle_ev);
    set_c:     cover property (@(posedge clk_in) set_cmd ##1 clr_cmd);
    dir_c:     cover property (@(posedge clk_in) wr_dir ##1 pin_oe_out);
    pwm_pin_c: cover property (@(posedge clk_in) gate_bit && pwm_bit && lvl_bit);

endmodule : timer6_mode_control

// >>> tb/tb_timer6_mode_control.sv
`timescale 1ns/100ps
`include "timer6_ctrl_defs.svh"
module tb_timer6_mode_control;
    logic                         clk_in = 1'b0;
    logic                         sys_rst_in = 1'b1;
    logic [15:0]                  addr_in = 16'h0000;
    logic [7:0]                   wdata_in = 8'h00;
    logic [7:0]                   wmask_in = 8'h00;
    logic                         wr_in = 1'b0;
    logic                         rd_in = 1'b0;
    logic                         match_in = 1'b0;
    logic                         count_wave_in = 1'b0;
    logic [1:0]                   port_latch_in = 2'h0;
    logic [7:0]                   rdata_out;
    logic [7:0]                   port10_direction_out;
    logic [7:0]                   rd_v;
    timer6_ctrl_pkg::timer_ctrl_t ctrl_out;
    logic                         count_clear_out;
    logic                         outff_out;
    logic                         timer6_wave_out;
    logic                         pin_oe_out;
    int                           error_cnt = 0;
    int                           n_compared = 0;

    timer6_mode_control DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wmask_in(wmask_in), .wr_in(wr_in), .rd_in(rd_in),
        .match_in(match_in), .count_wave_in(count_wave_in), .port_latch_in(port_latch_in),
        .rdata_out(rdata_out), .ctrl_out(ctrl_out), .count_clear_out(count_clear_out),
        .outff_out(outff_out), .timer6_wave_out(timer6_wave_out),
        .port10_direction_out(port10_direction_out), .pin_oe_out(pin_oe_out));

    always #2.5 clk_in = ~clk_in;

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wmask_in <= m;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [15:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_v = rdata_out;
    endtask : rd

    task t_reset;
        rd(`TMC_OFFSET);
        check(rd_v, 8'h00);
        check({ctrl_out, count_clear_out, outff_out, pin_oe_out, timer6_wave_out}, 8'h08);
        rd(`PORT_DIR_OFFSET);
        check(rd_v, 8'hFF);
        check(port10_direction_out, 8'hFF);
    endtask : t_reset

    task t_cmd;
        wr(`TMC_OFFSET, 8'h08, 8'hFF);
        check({7'h00, outff_out}, 8'h01);
        rd(`TMC_OFFSET);
        check(rd_v, 8'h00);
        wr(`TMC_OFFSET, 8'h0C, 8'hFF);
        check({7'h00, outff_out}, 8'h01);
        wr(`TMC_OFFSET, 8'h04, 8'hFF);
        check({7'h00, outff_out}, 8'h00);
        wr(`TMC_OFFSET, 8'h0C, 8'hFF);
        check({7'h00, outff_out}, 8'h00);
    endtask : t_cmd

    task t_toggle;
        wr(`TMC_OFFSET, 8'h82, 8'hFF);
        check({ctrl_out, 3'h0, count_clear_out}, 8'hA0);
        @(posedge clk_in);
        match_in <= 1'b1;
        @(posedge clk_in);
        match_in <= 1'b0;
        #1;
        check({6'h00, outff_out, timer6_wave_out}, 8'h02);
        wr(`TMC_OFFSET, 8'h00, 8'hFF);
        check({7'h00, count_clear_out}, 8'h01);
    endtask : t_toggle

    task t_modes;
        wr(`TMC_OFFSET, 8'hFF, 8'h01);
        wr(`TMC_OFFSET, 8'hFF, 8'h40);
        wr(`TMC_OFFSET, 8'h02, 8'h02);
        rd(`TMC_OFFSET);
        check(rd_v, 8'h43);
        check({7'h00, timer6_wave_out}, 8'h01);
        @(posedge clk_in);
        count_wave_in <= 1'b1;
        #1;
        check({7'h00, timer6_wave_out}, 8'h00);
        wr(`PORT_DIR_OFFSET, 8'hFD, 8'hFF);
        check(port10_direction_out, 8'hFD);
        check({7'h00, pin_oe_out}, 8'h01);
        wr(`PORT_DIR_OFFSET, 8'h02, 8'h02);
        check({7'h00, pin_oe_out}, 8'h00);
        wr(`TMC_OFFSET, 8'h00, 8'h01);
        check({7'h00, timer6_wave_out}, 8'h00);
        wr(16'h0000, 8'h55, 8'hFF);
        rd(16'h0000);
        check(rd_v, 8'h00);
    endtask : t_modes

    task stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_cmd();
        t_toggle();
        t_modes();
        stop_test();
    end

    // about 50 cycles expected; allow far more
    initial begin
        #5000;
        error_cnt++;
        stop_test();
    end
endmodule : tb_timer6_mode_control
